// ===== reset_power_save_control_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the design file and the testbench
`ifndef RESET_POWER_SAVE_CONTROL_REGS_SVH
`define RESET_POWER_SAVE_CONTROL_REGS_SVH
`define CLK_MHZ            200
`define OFF_CTRL           12'h000
`define OFF_RESET_CMD      12'h004
`define OFF_CONFIG         12'h008
`define OFF_TIMING_FLOOR   12'h00c
`define OFF_TIMING_CEIL    12'h010
`define OFF_ON_TIME        12'h014
`define OFF_SEARCH_PERIOD  12'h018
`define OFF_FIX_PERIOD     12'h01c
`define OFF_STATUS         12'h020
`define OFF_LOCK           12'h024
`define CMD_HW_NOW         8'h00
`define CMD_SW_FULL        8'h01
`define CMD_SW_GNSS        8'h02
`define CMD_HW_SHUTDOWN    8'h04
`define CMD_GNSS_STOP      8'h08
`define CMD_GNSS_START     8'h09
`define PIN_RESET_MS       1
`define PIN_RESET_CYCLES   (`PIN_RESET_MS * `CLK_MHZ * 1000)
`define FIX_PERIOD_MIN_MS  500
`define FIX_PERIOD_MAX_MS  10000
`define SHUTDOWN_CYCLES    16
`define TICK_US            1000
`define TICK_CYCLES        (`TICK_US * `CLK_MHZ)
`define CFG_MODE_LO        0
`define CFG_KEEP_TRY       2
`define CFG_WAKE_HOLD      3
`define CFG_RESET          32'h0000_0000
`endif

// ===== reset_power_save_control_pkg.sv
// Types for the reset and power-save controller
// Assumes the register header is present in the same folder
package reset_power_save_control_pkg;
  typedef enum logic [2:0] {
    ST_ACQ        = 3'b000,
    ST_TRACK      = 3'b001,
    ST_POT        = 3'b011,
    ST_IDLE_UPD   = 3'b010,
    ST_IDLE_SRCH  = 3'b110
  } pwr_state_t;
  typedef enum logic [1:0] {
    MODE_CONT = 2'h0,
    MODE_CT   = 2'h1,
    MODE_OO   = 2'h2
  } pwr_mode_t;
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_DRAIN = 2'b01,
    SEQ_PULSE = 2'b11
  } seq_state_t;
  typedef struct packed {
    logic fix_valid;
    logic sig_weak;
    logic sig_few;
    logic sig_none;
  } nav_status_t;
  typedef struct packed {
    logic clear_ram;
    logic clear_retained;
    logic wdog_reset;
    logic sys_restart;
    logic gnss_restart;
    logic gnss_stop;
    logic gnss_start;
  } reset_action_t;
endpackage

// ===== reset_power_save_control.sv
// Reset command sequencer, settings freeze and power-save state machine
// Assumes an APB master on core_clk and navigation status synchronous to it
//
// Summary of operation
// RULE_01 - Code 00: immediate watchdog reset, clear all
// RULE_02 - Code 04: shut down, then watchdog reset
// RULE_03 - Code 01: drain, restart, clear RAM only
// RULE_04 - Code 02: restart navigation tasks, clear nothing
// RULE_05 - Code 08 stops, 09 starts navigation
// RULE_06 - Reset pin low 1 ms clears all
// RULE_07 - Freeze rejects further configuration writes
// RULE_08 - Retained freeze persists, RAM freeze not
// RULE_09 - Five power-save states
// RULE_10 - Inactive states power down units
// RULE_11 - Optimised tracking loops, no acquisition/download
// RULE_12 - Cyclic 0.5-10 s, on/off beyond
// RULE_13 - Cyclic mode uses low-power tracking
// RULE_14 - On/off off period clears RAM
// RULE_15 - Weak signals: leave at ceiling or earlier
// RULE_16 - No signals: leave at ceiling
// RULE_17 - Poor signals: stay at least floor
// RULE_18 - Never exceed search ceiling
// RULE_19 - Keep-trying never enters inactive search
// RULE_20 - Continuous: acquisition engine only when needed
// RULE_21 - Fix enters tracking, else timed search
// RULE_22 - Wake hold with pin high blocks inactive
// RULE_23 - Current state readable
`timescale 1ns/10ps
`default_nettype none
`include "reset_power_save_control_regs.svh"
module reset_power_save_control
  import reset_power_save_control_pkg::*;
#(
  parameter int unsigned PIN_RESET_CYCLES = `PIN_RESET_CYCLES,
  parameter int unsigned TICK_CYCLES      = `TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        hw_reset_n,
  input  wire logic        ext_int,
  input  wire logic        tasks_idle,
  input  wire nav_status_t nav_status,
  output var  reset_action_t action,
  output var  logic        acq_engine_on,
  output var  logic        track_engine_on,
  output var  logic        low_power_track,
  output var  logic        units_off,
  output var  logic [2:0]  power_state
);
  localparam logic [15:0] SHUT_CNT = 16'(`SHUTDOWN_CYCLES);

  logic [31:0] config_reg;
  logic [15:0] search_time_floor;
  logic [15:0] search_time_ceiling;
  logic [15:0] on_time_period;
  logic [15:0] search_period;
  logic [15:0] fix_period_ms;
  logic        freeze_ram;
  logic        freeze_retained;
  logic        reject_flag;
  pwr_state_t  state;
  pwr_state_t  next_state;
  seq_state_t  seq;
  logic [7:0]  seq_code;
  logic [15:0] seq_cnt;
  logic [31:0] pin_cnt;
  logic        pin_reset;
  logic [31:0] tick_cnt;
  logic        tick;
  logic [15:0] state_ms;
  logic        hw_wipe;

  // Access phase start is the only edge that takes a request
  wire logic take = psel && penable && !pready;
  wire logic wr_en = take && pwrite;
  wire logic rd_en = take && !pwrite;
  wire logic frozen = freeze_ram || freeze_retained;
  wire logic cfg_addr = (paddr == `OFF_CONFIG) ||
                        (paddr == `OFF_TIMING_FLOOR) ||
                        (paddr == `OFF_TIMING_CEIL) ||
                        (paddr == `OFF_ON_TIME) ||
                        (paddr == `OFF_SEARCH_PERIOD) ||
                        (paddr == `OFF_FIX_PERIOD);
  wire logic mapped = cfg_addr ||
                      (paddr == `OFF_CTRL) ||
                      (paddr == `OFF_RESET_CMD) ||
                      (paddr == `OFF_STATUS) ||
                      (paddr == `OFF_LOCK);
  wire logic cfg_wr = wr_en && cfg_addr && !frozen; // RULE_07
  wire logic cmd_wr = wr_en && (paddr == `OFF_RESET_CMD) && pstrb[0];
  wire logic lock_wr = wr_en && (paddr == `OFF_LOCK);
  wire logic ctrl_wr = wr_en && (paddr == `OFF_CTRL);
  wire pwr_mode_t mode = pwr_mode_t'(config_reg[`CFG_MODE_LO +: 2]);
  wire logic keep_trying_option = config_reg[`CFG_KEEP_TRY];
  wire logic wake_hold_option = config_reg[`CFG_WAKE_HOLD];
  wire logic hold_awake = wake_hold_option && ext_int; // RULE_22
  wire logic poor_sig = nav_status.sig_none || nav_status.sig_weak;
  wire logic period_ok_ct = (fix_period_ms >= 16'(`FIX_PERIOD_MIN_MS)) &&
                            (fix_period_ms <= 16'(`FIX_PERIOD_MAX_MS)); // RULE_12
  wire logic eff_ct = (mode == MODE_CT) && period_ok_ct;
  wire logic eff_oo = (mode == MODE_OO) ||
                      ((mode == MODE_CT) && (fix_period_ms > 16'(`FIX_PERIOD_MAX_MS))); // RULE_12

  // APB slave, one wait state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= take;
      pslverr <= take && (!mapped || (pwrite && cfg_addr && frozen));
    end
  end

  // Read data, stands while pready is high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `OFF_CONFIG:        prdata <= config_reg;
        `OFF_TIMING_FLOOR:  prdata <= {16'h0000, search_time_floor};
        `OFF_TIMING_CEIL:   prdata <= {16'h0000, search_time_ceiling};
        `OFF_ON_TIME:       prdata <= {16'h0000, on_time_period};
        `OFF_SEARCH_PERIOD: prdata <= {16'h0000, search_period};
        `OFF_FIX_PERIOD:    prdata <= {16'h0000, fix_period_ms};
        `OFF_STATUS:        prdata <= {24'h000000, reject_flag, seq != SEQ_IDLE,
                                       pin_reset, 2'b00, state}; // RULE_23
        `OFF_LOCK:          prdata <= {30'h0, freeze_retained, freeze_ram};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || hw_wipe || (state == ST_IDLE_UPD && eff_oo)) begin
      config_reg          <= `CFG_RESET; // RULE_14
      search_time_floor   <= 16'h0000;
      search_time_ceiling <= 16'hffff;
      on_time_period      <= 16'h0000;
      search_period       <= 16'h0000;
      fix_period_ms       <= 16'h03e8;
    end else if (cfg_wr && pready == 1'b0) begin
      case (paddr)
        `OFF_CONFIG:        config_reg          <= pwdata;
        `OFF_TIMING_FLOOR:  search_time_floor   <= pwdata[15:0];
        `OFF_TIMING_CEIL:   search_time_ceiling <= pwdata[15:0];
        `OFF_ON_TIME:       on_time_period      <= pwdata[15:0];
        `OFF_SEARCH_PERIOD: search_period       <= pwdata[15:0];
        `OFF_FIX_PERIOD:    fix_period_ms       <= pwdata[15:0];
        default:            config_reg          <= config_reg;
      endcase
    end
  end

  // Settings freeze item, RAM layer
  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || hw_wipe) begin
      freeze_ram <= 1'b0;
    end else if ((seq == SEQ_DRAIN && seq_code == `CMD_SW_FULL && tasks_idle) ||
                 (state == ST_IDLE_UPD && eff_oo)) begin
      freeze_ram <= 1'b0; // RULE_08
    end else if (lock_wr && pwdata[0]) begin
      freeze_ram <= 1'b1;
    end
  end

  // Settings freeze item, retained layer, survives soft restarts
  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || hw_wipe) begin
      freeze_retained <= 1'b0; // RULE_08
    end else if (lock_wr && pwdata[1]) begin
      freeze_retained <= 1'b1;
    end
  end

  // Rejected write flag, set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reject_flag <= 1'b0;
    end else if (wr_en && !pready && cfg_addr && frozen) begin
      reject_flag <= 1'b1; // RULE_07
    end else if (ctrl_wr && pwdata[0]) begin
      reject_flag <= 1'b0;
    end
  end

  // Reset pin qualification
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_cnt   <= 32'h0;
      pin_reset <= 1'b0;
    end else if (hw_reset_n) begin
      pin_cnt   <= 32'h0;
      pin_reset <= 1'b0;
    end else if (pin_cnt >= PIN_RESET_CYCLES - 1) begin
      pin_reset <= 1'b1; // RULE_06
    end else begin
      pin_cnt <= pin_cnt + 32'h1;
    end
  end

  // Reset command sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq      <= SEQ_IDLE;
      seq_code <= 8'h00;
      seq_cnt  <= 16'h0;
      action   <= '0;
      hw_wipe  <= 1'b0;
    end else begin
      action  <= '0;
      hw_wipe <= 1'b0;
      // Entering the off period of on/off mode wipes working RAM
      if (state == ST_IDLE_UPD && eff_oo) begin
        action.clear_ram <= 1'b1; // RULE_14
      end
      case (seq)
        SEQ_IDLE: begin
          if (pin_reset) begin
            action <= '{clear_ram: 1'b1, clear_retained: 1'b1, wdog_reset: 1'b1,
                        default: 1'b0}; // RULE_06
          end else if (cmd_wr && !pready) begin
            seq_code <= pwdata[7:0];
            case (pwdata[7:0])
              `CMD_HW_NOW: begin
                action <= '{clear_ram: 1'b1, clear_retained: 1'b1, wdog_reset: 1'b1,
                            default: 1'b0}; // RULE_01
                hw_wipe <= 1'b1;
              end
              `CMD_HW_SHUTDOWN: begin
                action.gnss_stop <= 1'b1; // RULE_02
                seq_cnt <= SHUT_CNT;
                seq     <= SEQ_PULSE;
              end
              `CMD_SW_FULL: begin
                action.gnss_stop <= 1'b1; // RULE_03
                seq <= SEQ_DRAIN;
              end
              `CMD_SW_GNSS:    action.gnss_restart <= 1'b1; // RULE_04
              `CMD_GNSS_STOP:  action.gnss_stop    <= 1'b1; // RULE_05
              `CMD_GNSS_START: action.gnss_start   <= 1'b1; // RULE_05
              default:         seq <= SEQ_IDLE;
            endcase
          end
        end
        SEQ_DRAIN: begin
          if (tasks_idle) begin
            action <= '{clear_ram: 1'b1, sys_restart: 1'b1, default: 1'b0}; // RULE_03
            seq <= SEQ_IDLE;
          end
        end
        SEQ_PULSE: begin
          if (seq_cnt == 16'h0 && tasks_idle) begin
            action <= '{clear_ram: 1'b1, clear_retained: 1'b1, wdog_reset: 1'b1,
                        default: 1'b0}; // RULE_02
            hw_wipe <= 1'b1;
            seq <= SEQ_IDLE;
          end else if (seq_cnt != 16'h0) begin
            seq_cnt <= seq_cnt - 16'h1;
          end
        end
        default: seq <= SEQ_IDLE;
      endcase
    end
  end

  // Millisecond tick
  always_ff @(posedge core_clk) begin
    if (rst || tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0;
      tick     <= !rst;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // Power-save next state
  always_comb begin
    next_state = state;
    case (state)
      ST_ACQ: begin
        if (nav_status.fix_valid) begin
          next_state = ST_TRACK; // RULE_21
        end else if (!keep_trying_option && !hold_awake && mode != MODE_CONT) begin // RULE_19
          if (state_ms >= search_time_ceiling) begin
            next_state = ST_IDLE_SRCH; // RULE_16 RULE_18
          end else if (nav_status.sig_few && nav_status.sig_weak &&
                       !nav_status.sig_none && state_ms >= search_time_floor) begin
            next_state = ST_IDLE_SRCH; // RULE_15
          end
        end
      end
      ST_TRACK: begin
        if (!nav_status.fix_valid) begin
          next_state = ST_ACQ;
        end else if (state_ms >= on_time_period) begin
          if (eff_ct) begin
            next_state = ST_POT;
          end else if (eff_oo && !hold_awake) begin
            next_state = ST_IDLE_UPD; // RULE_22
          end
        end
      end
      ST_POT: begin
        if (!eff_ct || poor_sig || !nav_status.fix_valid) begin
          next_state = ST_TRACK;
        end
      end
      ST_IDLE_UPD: begin
        if (hold_awake || mode == MODE_CONT || state_ms >= fix_period_ms) begin
          next_state = ST_ACQ;
        end
      end
      ST_IDLE_SRCH: begin
        if (hold_awake || mode == MODE_CONT || state_ms >= search_period) begin
          next_state = ST_ACQ; // RULE_21
        end
      end
      default: next_state = ST_ACQ;
    endcase
  end

  // Power-save state and dwell timer
  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || action.sys_restart || action.wdog_reset) begin
      state    <= ST_ACQ; // RULE_09
      state_ms <= 16'h0;
    end else if (next_state != state) begin
      state    <= next_state;
      state_ms <= 16'h0;
    end else if (tick && state_ms != 16'hffff) begin
      state_ms <= state_ms + 16'h1; // RULE_17
    end
  end

  // Power-save state mirror and unit power
  always_ff @(posedge core_clk) begin
    if (rst) begin
      track_engine_on <= 1'b0;
      low_power_track <= 1'b0;
      units_off       <= 1'b0;
      power_state     <= 3'b000;
    end else begin
      power_state     <= state; // RULE_23
      units_off       <= (state == ST_IDLE_UPD) || (state == ST_IDLE_SRCH); // RULE_10
      low_power_track <= (state == ST_POT); // RULE_11 RULE_13
      track_engine_on <= (state == ST_TRACK) || (state == ST_POT);
    end
  end

  // Acquisition engine enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acq_engine_on <= 1'b0;
    end else if (mode == MODE_CONT) begin
      acq_engine_on <= nav_status.sig_few || nav_status.sig_none; // RULE_20
    end else begin
      acq_engine_on <= (state == ST_ACQ); // RULE_11
    end
  end
endmodule // reset_power_save_control
`default_nettype wire

// ===== reset_power_save_control_properties.sv
// Concurrent checks on the reset and power-save controller ports
// Assumes a bind onto reset_power_save_control, single clock core_clk
`timescale 1ns/10ps
`default_nettype none
module reset_power_save_control_properties
  import reset_power_save_control_pkg::*;
#(
  parameter int unsigned PIN_RESET_CYCLES = 200000
) (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          hw_reset_n,
  input wire reset_action_t action,
  input wire logic          acq_engine_on,
  input wire logic          units_off,
  input wire logic [2:0]    power_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  int unsigned low_cnt;
  logic        cmd_now;
  logic        idle_st;
  assign idle_st = power_state inside {ST_IDLE_UPD, ST_IDLE_SRCH};
  assign cmd_now = psel && penable && pwrite && pready && paddr == 12'h004
                   && pwdata[7:0] == 8'h00;
  // Cycles the reset pin has been low
  always_ff @(posedge core_clk) begin
    if (rst || hw_reset_n) begin
      low_cnt <= 0;
    end else if (low_cnt < PIN_RESET_CYCLES + 8) begin
      low_cnt <= low_cnt + 1;
    end
  end
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_reset_quiet: assert property ($fell(rst) |-> power_state == ST_ACQ && action == '0)
    else $error("outputs not quiet after reset");
  chk_cmd_now_wipe: assert property (
    cmd_now |-> ##[0:3] (action.wdog_reset && action.clear_ram && action.clear_retained))
    else $error("immediate reset did not wipe");
  chk_cmd_now_nostop: assert property (cmd_now |-> (!action.gnss_stop) [*4])
    else $error("stop event on immediate reset");
  chk_watchdog_wipe: assert property (
    action.wdog_reset |-> action.clear_ram && action.clear_retained && !action.sys_restart)
    else $error("watchdog reset without full wipe");
  chk_soft_keeps: assert property (
    action.sys_restart |-> action.clear_ram && !action.clear_retained)
    else $error("soft restart clears wrong stores");
  chk_nav_no_clear: assert property (
    (action.gnss_restart || action.gnss_stop || action.gnss_start)
    |-> !action.clear_ram && !action.clear_retained)
    else $error("navigation command cleared storage");
  chk_pin_wipe: assert property (
    low_cnt >= PIN_RESET_CYCLES + 6 |-> action.wdog_reset && action.clear_retained)
    else $error("long reset pin did not wipe");
  chk_state_legal: assert property (power_state inside {ST_ACQ, ST_TRACK, ST_POT,
    ST_IDLE_UPD, ST_IDLE_SRCH})
    else $error("illegal power state");
  chk_idle_units_off: assert property (idle_st && $past(idle_st) |-> units_off)
    else $error("units on while inactive");
  chk_pot_no_acq: assert property (
    power_state == ST_POT && $past(power_state) == ST_POT |-> !acq_engine_on)
    else $error("acquisition running in optimised tracking");
endmodule // reset_power_save_control_properties
bind reset_power_save_control reset_power_save_control_properties #(
  .PIN_RESET_CYCLES(PIN_RESET_CYCLES)
) i_reset_power_save_control_properties (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .hw_reset_n, .action, .acq_engine_on, .units_off, .power_state
);
`default_nettype wire

// ===== nav_engine_model.sv
// Navigation task engine seen from the controller
// Assumes action pulses from the controller on core_clk
`timescale 1ns/10ps
`default_nettype none
module nav_engine_model
  import reset_power_save_control_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire reset_action_t action,
  output wire logic          tasks_idle
);
  logic [3:0] drain_cnt;
  // Tasks wind down slowly after a stop, run again on any start
  always_ff @(posedge core_clk) begin
    if (rst || action.gnss_start || action.gnss_restart || action.sys_restart ||
        action.wdog_reset) begin
      drain_cnt <= 4'h0;
    end else if (action.gnss_stop) begin
      drain_cnt <= 4'h1;
    end else if (drain_cnt != 4'h0 && drain_cnt != 4'h9) begin
      drain_cnt <= drain_cnt + 4'h1;
    end
  end
  assign tasks_idle = (drain_cnt == 4'h9);
endmodule // nav_engine_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the reset and power-save controller
// Assumes package, header, checker and engine model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "reset_power_save_control_regs.svh"
module tb_top;
  import reset_power_save_control_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [3:0]    pstrb = 4'hf;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          hw_reset_n = 1'b1;
  logic          ext_int = 1'b0;
  wire logic     tasks_idle;
  nav_status_t   nav_status = 4'b0001;
  reset_action_t action;
  logic          acq_engine_on;
  logic          track_engine_on;
  logic          low_power_track;
  logic          units_off;
  logic [2:0]    power_state;
  logic [6:0]    seen = 7'h0;
  logic          clr = 1'b0;
  int            error_cnt = 0;
  int            n_checks = 0;
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) seen = clr ? 7'h0 : (seen | action);
  reset_power_save_control #(.PIN_RESET_CYCLES(20), .TICK_CYCLES(4)) i_reset_power_save_control (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_reset_n(hw_reset_n), .ext_int(ext_int), .tasks_idle(tasks_idle),
    .nav_status(nav_status), .action(action), .acq_engine_on(acq_engine_on),
    .track_engine_on(track_engine_on), .low_power_track(low_power_track),
    .units_off(units_off), .power_state(power_state));
  nav_engine_model i_nav_engine_model (
    .core_clk(core_clk), .rst(rst), .action(action), .tasks_idle(tasks_idle));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    chk("pready wait", 1, n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic clear_seen;
    clr = 1'b1;
    @(posedge core_clk);
    clr = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    clear_seen;
    wr(`OFF_RESET_CMD, {24'h0, c});
    repeat (60) @(posedge core_clk);
  endtask
  task automatic pin(input int n);
    clear_seen;
    hw_reset_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    hw_reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic wait_state(input logic [2:0] st, input string what);
    int n;
    n = 0;
    while (power_state !== st && n < 200) begin
      n++;
      @(posedge core_clk);
    end
    chk(what, st, power_state);
  endtask
  task automatic dwell(output int c);
    int n;
    n = 0;
    while (power_state !== ST_IDLE_SRCH && n < 300) begin
      n++;
      @(posedge core_clk);
    end
    while (power_state !== ST_ACQ && n < 600) begin
      n++;
      @(posedge core_clk);
    end
    c = 0;
    while (power_state === ST_ACQ && c < 300) begin
      c++;
      @(posedge core_clk);
    end
  endtask
  task automatic no_idle(input string what);
    int bad;
    bad = 0;
    wait_state(ST_ACQ, "awake before hold");
    repeat (150) begin
      @(posedge core_clk);
      if (power_state[1:0] !== 2'b00 && power_state[1:0] !== 2'b01 && power_state !== ST_POT) bad++;
    end
    chk(what, 0, bad);
  endtask
  task automatic t_start;
    logic [31:0] r;
    logic        e;
    rd_chk: begin
      apb(1'b0, `OFF_STATUS, 32'h0, r, e);
      chk("status state", ST_ACQ, r[2:0]);
      apb(1'b0, `OFF_TIMING_CEIL, 32'h0, r, e);
      chk("ceiling default", 32'hffff, r);
      apb(1'b0, 12'h0f0, 32'h0, r, e);
      chk("unmapped error", 1, e);
    end
    $display("start test done, mismatches %0d", error_cnt);
  endtask
  task automatic t_commands;
    logic [7:0] code [6];
    logic [6:0] want [6];
    code = '{8'h00, 8'h04, 8'h01, 8'h02, 8'h08, 8'h09};
    want = '{7'h70, 7'h72, 7'h4a, 7'h04, 7'h02, 7'h01};
    for (int i = 0; i < 6; i++) begin
      cmd(code[i]);
      chk("action set", want[i], seen);
    end
    $display("command test done, mismatches %0d", error_cnt);
  endtask
  task automatic t_lock;
    logic [31:0] r;
    logic        e;
    wr(`OFF_CONFIG, 32'h1);
    wr(`OFF_LOCK, 32'h1);
    apb(1'b1, `OFF_CONFIG, 32'h2, r, e);
    chk("frozen write error", 1, e);
    apb(1'b0, `OFF_CONFIG, 32'h0, r, e);
    chk("frozen config", 1, r);
    apb(1'b0, `OFF_STATUS, 32'h0, r, e);
    chk("reject flag", 1, r[7]);
    wr(`OFF_CTRL, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0, r, e);
    chk("reject cleared", 0, r[7]);
    cmd(`CMD_SW_FULL);
    apb(1'b1, `OFF_CONFIG, 32'h2, r, e);
    chk("ram freeze gone", 0, e);
    wr(`OFF_LOCK, 32'h2);
    cmd(`CMD_SW_FULL);
    apb(1'b1, `OFF_CONFIG, 32'h1, r, e);
    chk("retained freeze kept", 1, e);
    pin(10);
    chk("short pin no wipe", 0, seen[4]);
    pin(30);
    chk("pin wipe", 3'b111, seen[6:4]);
    apb(1'b1, `OFF_CONFIG, 32'h0, r, e);
    chk("freeze wiped", 0, e);
    $display("lock test done, mismatches %0d", error_cnt);
  endtask
  task automatic t_psm;
    int c;
    nav_status <= 4'b1000;
    repeat (30) @(posedge core_clk);
    chk("continuous tracking engine", 2'b01, {acq_engine_on, track_engine_on});
    nav_status <= 4'b0010;
    repeat (30) @(posedge core_clk);
    chk("continuous acquisition", 1, acq_engine_on);
    wr(`OFF_TIMING_FLOOR, 32'd4);
    wr(`OFF_TIMING_CEIL, 32'd20);
    wr(`OFF_ON_TIME, 32'd2);
    wr(`OFF_SEARCH_PERIOD, 32'd3);
    nav_status <= 4'b0001;
    wr(`OFF_CONFIG, 32'h1);
    dwell(c);
    chk("no signal dwell", 1, c >= 72 && c <= 88);
    chk("idle units off", 1, units_off);
    nav_status <= 4'b0110;
    dwell(c);
    chk("weak dwell", 1, c >= 12 && c <= 40);
    wr(`OFF_CONFIG, 32'h5);
    no_idle("keep trying");
    ext_int <= 1'b1;
    wr(`OFF_CONFIG, 32'h9);
    no_idle("wake hold");
    ext_int <= 1'b0;
    nav_status <= 4'b1000;
    wait_state(ST_TRACK, "fix to tracking");
    wait_state(ST_POT, "on time to optimised");
    chk("low power tracking", 1, low_power_track);
    nav_status <= 4'b0001;
    wait_state(ST_IDLE_SRCH, "lost to search");
    wr(`OFF_FIX_PERIOD, 32'd20000);
    clear_seen;
    nav_status <= 4'b1000;
    wait_state(ST_IDLE_UPD, "long period off");
    chk("off clears ram", 1, seen[6]);
    $display("power save test done, mismatches %0d", error_cnt);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_start;
    t_commands;
    t_lock;
    t_psm;
    print_verdict;
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
